// ---- src_pkg.sv ----
// constants, register map and types of the software reset commander
// assumes a 32-bit ahb-lite slave port and a free-running slow clock level
package src_pkg;

  // register byte offsets
  localparam logic [7:0] SRC_ADDR_CMD   = 8'h00;
  localparam logic [7:0] SRC_ADDR_MODE  = 8'h04;
  localparam logic [7:0] SRC_ADDR_STAT  = 8'h08;
  localparam logic [7:0] SRC_ADDR_ISTAT = 8'h0C;
  localparam logic [7:0] SRC_ADDR_IMASK = 8'h10;

  // reset_command_reg bit positions
  localparam int SRC_CMD_CPU_BIT    = 0;
  localparam int SRC_CMD_PERIPH_BIT = 2;
  localparam int SRC_CMD_EXT_BIT    = 3;

  // reset_mode_reg: ext_reset_length field
  localparam int              SRC_LEN_LSB   = 8;
  localparam int              SRC_LEN_W     = 4;
  localparam logic [3:0]      SRC_LEN_RST   = 4'h0;

  // reset_status_reg fields
  localparam int              SRC_BUSY_BIT  = 16;
  localparam int              SRC_CAUSE_LSB = 8;
  localparam int              SRC_CAUSE_W   = 3;
  localparam logic [2:0]      SRC_CAUSE_RST  = 3'h0;
  localparam logic [2:0]      SRC_CAUSE_SW   = 3'h3;
  localparam logic [2:0]      SRC_CAUSE_USER = 3'h4;

  // interrupt status and mask layout
  localparam int              SRC_IRQ_W        = 2;
  localparam int              SRC_IRQ_DONE_BIT = 0;
  localparam int              SRC_IRQ_USER_BIT = 1;
  localparam logic [1:0]      SRC_IRQ_RST      = 2'h0;

  // software reset length in slow clock cycles
  localparam logic [1:0]      SRC_SW_SLOW_CYCLES = 2'h3;

  // external pin low-time counter width
  localparam int              SRC_EXT_CNT_W = 20;

  typedef enum logic [1:0] {
    SRC_SEQ_IDLE = 2'b01,
    SRC_SEQ_RUN  = 2'b10
  } src_seq_t;

endpackage

// ---- src_slow_tick.sv ----
// rising-edge detector for the slow clock level
// assumes slow_clock is already synchronous to hclk
`timescale 1ns/100ps
module src_slow_tick
  import src_pkg::*;
(
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // slow clock level and its edge
  input  wire logic slow_clock,
  output logic      slow_tick
);

  logic prev_reg;
  logic prev_next;

  always_comb begin
    prev_next = slow_clock;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
    end
  end

  assign slow_tick = slow_clock & ~prev_reg;

endmodule

// ---- src_ext_pulse.sv ----
// low-time timer for the external reset pin, counted in slow clock ticks
// assumes one-cycle start and tick pulses in the hclk domain
`timescale 1ns/100ps
module src_ext_pulse
  import src_pkg::*;
#(
  parameter int unsigned EXT_SHIFT = 0
)
(
  // clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // control
  input  wire logic                 start,
  input  wire logic [SRC_LEN_W-1:0] length,
  input  wire logic                 slow_tick,
  // pin drive request
  output logic                      drive_active
);

  logic [SRC_EXT_CNT_W-1:0] cnt_reg;
  logic [SRC_EXT_CNT_W-1:0] cnt_next;
  logic                     act_reg;
  logic                     act_next;
  logic [SRC_EXT_CNT_W-1:0] load;

  always_comb begin
    // low time is (length + 1) << EXT_SHIFT slow cycles
    load     = (SRC_EXT_CNT_W'(length) + 1'b1) << EXT_SHIFT;
    cnt_next = cnt_reg;
    act_next = act_reg;
    if (start) begin
      cnt_next = load;
      act_next = 1'b1;
    end else if (act_reg && slow_tick) begin
      if (cnt_reg <= SRC_EXT_CNT_W'(1)) begin
        cnt_next = '0;
        act_next = 1'b0;
      end else begin
        cnt_next = cnt_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= '0;
      act_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      act_reg <= act_next;
    end
  end

  assign drive_active = act_reg;

endmodule

// ---- src_commander.sv ----
// software reset commander with ahb-lite register access
// assumes a single ahb-lite master, hclk as master clock and slow_clock
// as a level sampled on hclk; the external reset pin is open drain
//
// Overview of operation
// - cpu command bit resets processor core and watchdog during the software reset.
// - peripheral command bit resets all peripherals, memory system and remap setting.
// - external command bit pulls the reset pin low for the programmed length.
// - any nonzero combination of the three command bits starts a software reset.
// - a software reset ends on the third slow clock edge after acceptance; its first slow cycle may be partial.
// - selected reset outputs assert as soon as the command write is seen.
// - internal reset outputs release when the software reset ends, on a slow clock edge.
// - the pin's falling edge caused by the external command is no user reset.
// - reset cause records software only when the cpu bit was commanded.
// - in-progress flag sets on command detection, clears when the reset ends.
// - command writes are ignored and no reset starts while in progress.
//
// The placing of the registers and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/100ps
module src_commander
  import src_pkg::*;
#(
  parameter int unsigned EXT_SHIFT = 0
)
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // slow clock level
  input  wire logic        slow_clock,
  // internal reset outputs, active high
  output logic             cpu_wdt_reset,
  output logic             periph_reset,
  // open-drain external reset pin
  input  wire logic        ext_rst_pin_in,
  output logic             ext_rst_pin_out,
  output logic             ext_rst_pin_oe,
  // status and interrupt
  output logic             sw_reset_in_progress,
  output logic             user_reset_event,
  output logic             irq
);

  // ahb address phase capture
  logic                   ap_valid_reg;
  logic                   ap_valid_next;
  logic                   ap_write_reg;
  logic                   ap_write_next;
  logic [7:0]             ap_addr_reg;
  logic [7:0]             ap_addr_next;
  logic [31:0]            rdata_reg;
  logic [31:0]            rdata_next;

  // software registers
  logic [SRC_LEN_W-1:0]   len_reg;
  logic [SRC_LEN_W-1:0]   len_next;
  logic [SRC_CAUSE_W-1:0] cause_reg;
  logic [SRC_CAUSE_W-1:0] cause_next;
  logic [SRC_IRQ_W-1:0]   istat_reg;
  logic [SRC_IRQ_W-1:0]   istat_next;
  logic [SRC_IRQ_W-1:0]   imask_reg;
  logic [SRC_IRQ_W-1:0]   imask_next;

  // sequencer
  src_seq_t               seq_reg;
  src_seq_t               seq_next;
  logic [1:0]             slow_cnt_reg;
  logic [1:0]             slow_cnt_next;
  logic                   busy_reg;
  logic                   busy_next;
  logic                   cpu_rst_reg;
  logic                   cpu_rst_next;
  logic                   per_rst_reg;
  logic                   per_rst_next;

  // user reset detector
  logic                   pin_prev_reg;
  logic                   pin_prev_next;
  logic                   guard_reg;
  logic                   guard_next;

  // decoded strobes and events
  logic                   addr_phase;
  logic                   wr_phase;
  logic                   cmd_wr;
  logic                   cmd_any;
  logic                   accept;
  logic                   ext_start;
  logic                   done_evt;
  logic                   user_evt;
  logic                   slow_tick;
  logic                   ext_drive;
  logic                   mode_wr;
  logic                   imask_wr;
  logic                   istat_wr;
  logic                   cpu_cmd;
  logic                   per_cmd;
  logic                   ext_cmd;
  logic [7:0]             rd_addr;
  logic [31:0]            stat_word;

  src_slow_tick u_tick (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .slow_clock (slow_clock),
    .slow_tick  (slow_tick)
  );

  // pin low time runs in slow ticks from the length field
  src_ext_pulse #(
    .EXT_SHIFT (EXT_SHIFT)
  ) u_ext (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .start        (ext_start),
    .length       (len_reg),
    .slow_tick    (slow_tick),
    .drive_active (ext_drive)
  );

  // bus front end: zero wait states, only word transfers are expected
  always_comb begin
    addr_phase    = hsel && hready && htrans[1];
    ap_valid_next = addr_phase;
    ap_write_next = addr_phase ? hwrite : ap_write_reg;
    ap_addr_next  = addr_phase ? {haddr[7:2], 2'b00} : ap_addr_reg;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid_reg <= 1'b0;
      ap_write_reg <= 1'b0;
      ap_addr_reg  <= 8'h00;
    end else begin
      ap_valid_reg <= ap_valid_next;
      ap_write_reg <= ap_write_next;
      ap_addr_reg  <= ap_addr_next;
    end
  end

  // command decode in the write data phase
  always_comb begin
    wr_phase  = ap_valid_reg && ap_write_reg;
    cmd_wr    = wr_phase && (ap_addr_reg == SRC_ADDR_CMD);
    mode_wr   = wr_phase && (ap_addr_reg == SRC_ADDR_MODE);
    imask_wr  = wr_phase && (ap_addr_reg == SRC_ADDR_IMASK);
    istat_wr  = wr_phase && (ap_addr_reg == SRC_ADDR_ISTAT);
    cpu_cmd   = hwdata[SRC_CMD_CPU_BIT];
    per_cmd   = hwdata[SRC_CMD_PERIPH_BIT];
    ext_cmd   = hwdata[SRC_CMD_EXT_BIT];
    cmd_any   = cpu_cmd | per_cmd | ext_cmd;
    // a command write while busy is dropped whole: no pin, no cause change
    accept    = cmd_wr && cmd_any && !busy_reg;
    ext_start = accept && ext_cmd;
  end

  // software reset sequencer
  always_comb begin
    seq_next      = seq_reg;
    slow_cnt_next = slow_cnt_reg;
    busy_next     = busy_reg;
    cpu_rst_next  = cpu_rst_reg;
    per_rst_next  = per_rst_reg;
    done_evt      = 1'b0;
    case (seq_reg)
      SRC_SEQ_IDLE: begin
        if (accept) begin
          seq_next      = SRC_SEQ_RUN;
          slow_cnt_next = 2'h0;
          busy_next     = 1'b1;
          cpu_rst_next  = cpu_cmd;
          per_rst_next  = per_cmd;
        end
      end
      // counting starts at acceptance, so the first slow cycle may be partial
      SRC_SEQ_RUN: begin
        if (slow_tick) begin
          if (slow_cnt_reg == SRC_SW_SLOW_CYCLES - 2'h1) begin
            seq_next      = SRC_SEQ_IDLE;
            slow_cnt_next = 2'h0;
            busy_next     = 1'b0;
            cpu_rst_next  = 1'b0;
            per_rst_next  = 1'b0;
            done_evt      = 1'b1;
          end else begin
            slow_cnt_next = slow_cnt_reg + 2'h1;
          end
        end
      end
      default: begin
        seq_next      = SRC_SEQ_IDLE;
        slow_cnt_next = 2'h0;
        busy_next     = 1'b0;
        cpu_rst_next  = 1'b0;
        per_rst_next  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seq_reg      <= SRC_SEQ_IDLE;
      slow_cnt_reg <= 2'h0;
      busy_reg     <= 1'b0;
      cpu_rst_reg  <= 1'b0;
      per_rst_reg  <= 1'b0;
    end else begin
      seq_reg      <= seq_next;
      slow_cnt_reg <= slow_cnt_next;
      busy_reg     <= busy_next;
      cpu_rst_reg  <= cpu_rst_next;
      per_rst_reg  <= per_rst_next;
    end
  end

  // user reset detector; the guard holds from our own drive until the
  // pin is seen high again, so a slow pull-up cannot fake a user reset
  always_comb begin
    pin_prev_next = ext_rst_pin_in;
    guard_next    = ext_drive | (guard_reg & ~ext_rst_pin_in);
    user_evt      = pin_prev_reg && !ext_rst_pin_in
                    && !guard_reg && !ext_drive;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_prev_reg <= 1'b1;
      guard_reg    <= 1'b0;
    end else begin
      pin_prev_reg <= pin_prev_next;
      guard_reg    <= guard_next;
    end
  end

  // software-visible registers
  always_comb begin
    len_next   = len_reg;
    cause_next = cause_reg;
    imask_next = imask_reg;
    istat_next = istat_reg;
    if (mode_wr) begin
      len_next = hwdata[SRC_LEN_LSB +: SRC_LEN_W];
    end
    if (imask_wr) begin
      imask_next = hwdata[SRC_IRQ_W-1:0];
    end
    if (istat_wr) begin
      istat_next = istat_reg & ~hwdata[SRC_IRQ_W-1:0];
    end
    // a new event wins over a clear in the same cycle
    if (done_evt) begin
      istat_next[SRC_IRQ_DONE_BIT] = 1'b1;
    end
    if (user_evt) begin
      istat_next[SRC_IRQ_USER_BIT] = 1'b1;
    end
    // a processor reset outranks a user reset seen in the same cycle
    if (accept && cpu_cmd) begin
      cause_next = SRC_CAUSE_SW;
    end else if (user_evt) begin
      cause_next = SRC_CAUSE_USER;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      len_reg   <= SRC_LEN_RST;
      cause_reg <= SRC_CAUSE_RST;
      imask_reg <= SRC_IRQ_RST;
      istat_reg <= SRC_IRQ_RST;
    end else begin
      len_reg   <= len_next;
      cause_reg <= cause_next;
      imask_reg <= imask_next;
      istat_reg <= istat_next;
    end
  end

  // status word as software sees it after this edge
  always_comb begin
    stat_word                               = 32'h0000_0000;
    stat_word[SRC_BUSY_BIT]                 = busy_next;
    stat_word[SRC_CAUSE_LSB +: SRC_CAUSE_W] = cause_next;
  end

  // read data is taken from next-state values so that a write in the
  // preceding data phase is already visible to a back-to-back read
  always_comb begin
    rd_addr    = {haddr[7:2], 2'b00};
    rdata_next = 32'h0000_0000;
    if (addr_phase && !hwrite) begin
      case (rd_addr)
        SRC_ADDR_MODE: begin
          rdata_next[SRC_LEN_LSB +: SRC_LEN_W] = len_next;
        end
        SRC_ADDR_STAT: begin
          rdata_next = stat_word;
        end
        SRC_ADDR_ISTAT: begin
          rdata_next[SRC_IRQ_W-1:0] = istat_next;
        end
        SRC_ADDR_IMASK: begin
          rdata_next[SRC_IRQ_W-1:0] = imask_next;
        end
        default: begin
          rdata_next = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // outputs
  assign hreadyout            = 1'b1;
  assign hresp                = 1'b0;
  assign hrdata               = rdata_reg;
  assign cpu_wdt_reset        = cpu_rst_reg;
  assign periph_reset         = per_rst_reg;
  // open drain: only ever pulled low, the pull-up gives the high level
  assign ext_rst_pin_out      = 1'b0;
  assign ext_rst_pin_oe       = ext_drive;
  assign sw_reset_in_progress = busy_reg;
  assign user_reset_event     = user_evt;
  assign irq                  = |(istat_reg & imask_reg);

endmodule

// ---- src_commander_asserts.sv ----
// concurrent checks on the ports of the software reset commander
// assumes a bind into src_commander and slow_clock sampled on hclk
`timescale 1ns/100ps
module src_commander_asserts
  import src_pkg::*;
#(
  parameter int unsigned EXT_SHIFT = 0
)
(
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // slow clock, resets and status
  input wire logic        slow_clock,
  input wire logic        cpu_wdt_reset,
  input wire logic        periph_reset,
  input wire logic        ext_rst_pin_oe,
  input wire logic        sw_reset_in_progress,
  input wire logic        user_reset_event
);
  logic       cmd_wr_reg;
  logic       cmd_wr_next;
  logic       slow_reg;
  logic [3:0] slow_cnt_reg;
  logic [3:0] slow_cnt_next;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // slow edges are only counted while a reset runs, so the count is per reset
  always_comb begin
    cmd_wr_next   = hsel && hready && htrans[1] && hwrite && (haddr[7:2] == SRC_ADDR_CMD[7:2]);
    slow_cnt_next = sw_reset_in_progress ? slow_cnt_reg + {3'h0, slow_clock & ~slow_reg} : 4'h0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_wr_reg   <= 1'b0;
      slow_reg     <= 1'b0;
      slow_cnt_reg <= 4'h0;
    end else begin
      cmd_wr_reg   <= cmd_wr_next;
      slow_reg     <= slow_clock;
      slow_cnt_reg <= slow_cnt_next;
    end
  end

  sequence cmd_taken(int b);
    cmd_wr_reg && hwdata[b] && !sw_reset_in_progress;
  endsequence

  sequence cmd_empty;
    cmd_wr_reg && !sw_reset_in_progress && !(hwdata[0] || hwdata[2] || hwdata[3]);
  endsequence

  cpu_start_a: assert property (cmd_taken(SRC_CMD_CPU_BIT) |=>
                                cpu_wdt_reset && sw_reset_in_progress)
    else $error("cpu reset not raised by command");
  periph_start_a: assert property (cmd_taken(SRC_CMD_PERIPH_BIT) |=> periph_reset && sw_reset_in_progress)
    else $error("peripheral reset not raised by command");
  ext_start_a: assert property (cmd_taken(SRC_CMD_EXT_BIT) |=> ext_rst_pin_oe && sw_reset_in_progress)
    else $error("reset pin not pulled by command");
  empty_cmd_a: assert property (cmd_empty |=> !sw_reset_in_progress)
    else $error("reset started without command bits");
  busy_ignore_a: assert property (cmd_wr_reg && sw_reset_in_progress && !periph_reset |=> !periph_reset)
    else $error("command taken while busy");
  three_slow_a: assert property ($fell(sw_reset_in_progress) |-> slow_cnt_reg == 4'h3)
    else $error("software reset length not three slow cycles");
  release_end_a: assert property (cpu_wdt_reset || periph_reset |-> sw_reset_in_progress)
    else $error("internal reset outlives the busy flag");
  pin_no_user_a: assert property (ext_rst_pin_oe |-> !user_reset_event)
    else $error("own pin drive seen as user reset");
  pin_start_a: assert property ($rose(ext_rst_pin_oe) |-> sw_reset_in_progress)
    else $error("pin driven outside a software reset");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus wait or error response");
endmodule

bind src_commander src_commander_asserts #(.EXT_SHIFT(EXT_SHIFT)) src_commander_asserts_i (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp,
  .slow_clock, .cpu_wdt_reset, .periph_reset, .ext_rst_pin_oe, .sw_reset_in_progress, .user_reset_event
);

// ---- src_far_model.sv ----
// far side of the commander: slow clock source and the external reset line
// assumes the line has a pull-up and a push button to ground
`timescale 1ns/100ps
module src_far_model #(
  parameter int unsigned SLOW_HALF = 4
)
(
  // master clock
  input  wire logic hclk,
  // pin drive from the commander, push button
  input  wire logic pin_out,
  input  wire logic pin_oe,
  input  wire logic user_push,
  // far side levels
  output logic      slow_clock,
  output logic      pin_level
);
  int unsigned div_cnt;

  initial begin
    slow_clock = 1'b0;
    div_cnt    = 0;
  end

  // the slow oscillator runs free; it changes just after hclk edges
  always @(posedge hclk) begin
    if (div_cnt == SLOW_HALF - 1) begin
      div_cnt    <= 0;
      slow_clock <= ~slow_clock;
    end else begin
      div_cnt <= div_cnt + 1;
    end
  end

  // wired-and with pull-up: high unless one party pulls it low
  assign pin_level = ((pin_oe && !pin_out) || user_push) ? 1'b0 : 1'b1;
endmodule

// ---- software_reset_commander_tb_top.sv ----
// self-checking bench for the software reset commander
// assumes src_far_model for slow clock and pin; single ahb-lite master here
`timescale 1ns/100ps
module software_reset_commander_tb_top;
  import src_pkg::*;
  localparam int SLOW_HALF = 4;
  localparam int P         = 2 * SLOW_HALF;

  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, rdy_q, user_push;
  logic        slow_clock, pin_level, cpu_wdt_reset, periph_reset, irq;
  logic        ext_rst_pin_out, ext_rst_pin_oe, sw_reset_in_progress, user_reset_event;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [2:0]  cause_exp;
  logic [3:0]  cmd;
  logic [31:0] haddr, hwdata, hrdata, rd_q, rd;
  int          err_count, num_checks, ue_cnt, ue0, oe_len, busy_len, lo, hi, n;
  logic [3:0]  cmds [4] = '{4'h4, 4'h8, 4'hD, 4'h1}; // peripheral-only is the debug case
  logic [3:0]  lens [4] = '{4'h0, 4'h0, 4'h2, 4'h1};
  logic [7:0]  regs [6] = '{SRC_ADDR_CMD, SRC_ADDR_MODE, SRC_ADDR_STAT, SRC_ADDR_ISTAT, SRC_ADDR_IMASK, 8'h14};

  src_commander #(.EXT_SHIFT(0)) src_commander_i (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
    .hresp, .hrdata, .slow_clock, .cpu_wdt_reset, .periph_reset, .ext_rst_pin_in(pin_level),
    .ext_rst_pin_out, .ext_rst_pin_oe, .sw_reset_in_progress, .user_reset_event, .irq
  );

  src_far_model #(.SLOW_HALF(SLOW_HALF)) src_far_model_i (
    .hclk, .pin_out(ext_rst_pin_out), .pin_oe(ext_rst_pin_oe), .user_push, .slow_clock, .pin_level
  );

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  // copies taken at the edge, so reads never race the design's flops
  always @(posedge hclk) begin
    rdy_q <= hreadyout;
    rd_q  <= hrdata;
    if (user_reset_event === 1'b1) ue_cnt <= ue_cnt + 1;
    if (ext_rst_pin_oe === 1'b1) oe_len <= oe_len + 1;
    if (sw_reset_in_progress === 1'b1) busy_len <= busy_len + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic span(input int got, input int lo_v, input int hi_v);
    num_checks++;
    if (got < lo_v || got > hi_v) begin
      err_count++;
      $display("wrong value at %0t: span %0d outside %0d..%0d", $time, got, lo_v, hi_v);
    end
  endtask

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {24'h00_0000, a};
    do begin @(posedge hclk); #1; end while (rdy_q !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do begin @(posedge hclk); #1; end while (rdy_q !== 1'b1);
    rd = rd_q;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #(20000 * 5);
    err_count++;
    report_and_stop();
  end

  initial begin
    hresetn = 1'b0; hsel = 1'b0; htrans = 2'b00; hwrite = 1'b0; hsize = 3'h2;
    haddr = 32'h0000_0000; hwdata = 32'h0000_0000; user_push = 1'b0;
    err_count = 0; num_checks = 0; ue_cnt = 0; oe_len = 0; busy_len = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk); #1;
    foreach (regs[i]) rdchk(regs[i], 32'h0000_0000);
    xfer(1'b1, 8'h14, 32'hFFFF_FFFF);
    rdchk(8'h14, 32'h0000_0000);
    xfer(1'b1, SRC_ADDR_CMD, 32'h0000_0002);
    chk({31'h0, sw_reset_in_progress}, 32'h0000_0000);
    // a press on the button is a user reset
    user_push <= 1'b1;
    repeat (4) @(posedge hclk); #1;
    user_push <= 1'b0;
    repeat (2) @(posedge hclk); #1;
    chk(ue_cnt, 32'h0000_0001);
    rdchk(SRC_ADDR_STAT, {21'h00_0000, SRC_CAUSE_USER, 8'h00});
    rdchk(SRC_ADDR_ISTAT, 32'h0000_0002);
    xfer(1'b1, SRC_ADDR_ISTAT, 32'h0000_0003);
    cause_exp = SRC_CAUSE_USER;
    for (int i = 0; i < 4; i++) begin
      cmd = cmds[i];
      xfer(1'b1, SRC_ADDR_MODE, {20'h0_0000, lens[i], 8'h00});
      rdchk(SRC_ADDR_MODE, {20'h0_0000, lens[i], 8'h00});
      ue0 = ue_cnt; oe_len = 0; busy_len = 0;
      xfer(1'b1, SRC_ADDR_CMD, {28'h000_0000, cmd});
      chk({cpu_wdt_reset, periph_reset}, {cmd[0], cmd[2]});
      chk({ext_rst_pin_oe, sw_reset_in_progress}, {cmd[3], 1'b1});
      if (cmd[0]) cause_exp = SRC_CAUSE_SW;
      rdchk(SRC_ADDR_STAT, {15'h0000, 1'b1, 5'h00, cause_exp, 8'h00});
      xfer(1'b1, SRC_ADDR_CMD, 32'h0000_000D);
      chk({cpu_wdt_reset, periph_reset}, {cmd[0], cmd[2]});
      n = 0;
      while ((sw_reset_in_progress !== 1'b0 || ext_rst_pin_oe !== 1'b0) && n < 500) begin
        @(posedge hclk); #1; n++;
      end
      span(n, 0, 499);
      span(busy_len, 2 * P, 3 * P + 2);
      lo = cmd[3] ? lens[i] * P : 0;
      hi = cmd[3] ? (lens[i] + 1) * P + 2 : 0;
      span(oe_len, lo, hi);
      chk(ue_cnt, ue0);
      chk({cpu_wdt_reset, periph_reset, ext_rst_pin_oe}, 3'b000);
      rdchk(SRC_ADDR_STAT, {21'h00_0000, cause_exp, 8'h00});
      rdchk(SRC_ADDR_ISTAT, 32'h0000_0001);
      chk(irq, 1'b0);
      xfer(1'b1, SRC_ADDR_IMASK, 32'h0000_0001);
      chk(irq, 1'b1);
      xfer(1'b1, SRC_ADDR_ISTAT, 32'h0000_0001);
      chk(irq, 1'b0);
      xfer(1'b1, SRC_ADDR_IMASK, 32'h0000_0000);
    end
    report_and_stop();
  end
endmodule
